//--- pkg/pic_pkg.sv
`default_nettype none
package pic_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_EN_LO = 8'h3A;
  localparam logic [7:0] ADDR_EN_HI = 8'h3B;
  localparam logic [7:0] ADDR_IL_LO = 8'h3C;
  localparam logic [7:0] ADDR_IL_HI = 8'h3D;
  localparam logic [7:0] ADDR_SEL = 8'h3E;
  // field positions
  localparam int IMF_BIT = 0;
  localparam int SEL16_BIT = 0;
  localparam int SEL15_BIT = 1;
  // source indices
  localparam int IDX_TRAP = 1;
  localparam int IDX_ATRAP = 2;
  localparam int IDX_WDT = 3;
  localparam int IDX_MASK_LO = 4;
  localparam int IDX_SHARED15 = 14;
  localparam int IDX_SHARED16 = 15;
  localparam int NUM_SRC = 18;
  // vectors
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_SEL = 2'h0;
  // timing: clocks per machine cycle, machine cycles of acceptance, stack pushes
  localparam int MACHINE_CLKS = 4;
  localparam int ACCEPT_MCYC = 8;
  localparam int STACK_PUSHES = 3;
  localparam int CNT_W = 8;
  // stack slot codes
  localparam logic [1:0] SLOT_STATUS = 2'h0;
  localparam logic [1:0] SLOT_PCH = 2'h1;
  localparam logic [1:0] SLOT_PCL = 2'h2;
  typedef enum logic [1:0] {
    PIC_IDLE = 2'b00,
    PIC_ACCEPT = 2'b01
  } pic_state_t;
endpackage
`default_nettype wire

//--- pkg/pic_arb_if.sv
`default_nettype none
interface pic_arb_if;
  logic [15:0] req;
  logic win_valid;
  logic [3:0] win_idx;
  logic [15:0] win_vector;
  modport ctrl (output req, input win_valid, input win_idx, input win_vector);
  modport arb (input req, output win_valid, output win_idx, output win_vector);
endinterface
`default_nettype wire

//--- core/pic_arbiter.sv
`default_nettype none
module pic_arbiter (
  // request side
  pic_arb_if.arb arb
);
  always_comb begin
    arb.win_valid = 1'b0;
    arb.win_idx = 4'h0;
    // lowest index wins; the two trap sources share index 1
    for (int i = 15; i >= 1; i--) begin
      if (arb.req[i]) begin
        arb.win_valid = 1'b1;
        arb.win_idx = 4'(i);
      end
    end
    // vectors step down by two from the reset vector
    arb.win_vector = pic_pkg::VEC_RESET - {11'h000, arb.win_idx, 1'b0};
  end
endmodule
`default_nettype wire

//--- core/pic_top.sv
`default_nettype none
module pic_top #(
  parameter int MACHINE_CLKS = pic_pkg::MACHINE_CLKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // request sources
  input wire logic software_trap,
  input wire logic undefined_opcode_trap,
  input wire logic address_trap_irq,
  input wire logic watchdog_irq,
  input wire logic [13:4] maskable_irq,
  input wire logic external_pin_four_irq,
  input wire logic serial_transmit_irq,
  input wire logic external_pin_five_irq,
  input wire logic converter_done_irq,
  // watchdog control bits
  input wire logic trap_reset_select,
  input wire logic wdt_reset_select,
  // cpu sequencer
  input wire logic instr_done,
  input wire logic enable_irq_op,
  input wire logic disable_irq_op,
  input wire logic maskable_return_op,
  input wire logic nonmaskable_return_op,
  input wire logic restored_imf,
  output logic int_req,
  output logic accept_busy,
  output logic stack_push,
  output logic [1:0] stack_slot,
  output logic stack_imf,
  output logic vector_valid,
  output logic [15:0] int_vector,
  // reset requests
  output logic trap_reset_req,
  output logic wdt_reset_req
);

  localparam int ACC_CLKS = pic_pkg::ACCEPT_MCYC * MACHINE_CLKS;

  typedef struct packed {
    pic_pkg::pic_state_t st;
    logic [pic_pkg::CNT_W-1:0] cnt;
    logic master_enable_flag;
    logic [15:4] source_enable_flag;
    logic [15:2] pending_latch;
    logic level15_source_select;
    logic level16_source_select;
    logic [3:0] win;
    logic saved_imf;
    logic int_req;
    logic busy;
    logic push;
    logic [1:0] slot;
    logic vvalid;
    logic [15:0] vector;
    logic [7:0] rdata;
    logic trap_rst;
    logic wdt_rst;
  } pic_regs_t;

  pic_regs_t q_r;
  pic_regs_t q_nxt;
  logic [15:2] set_v;
  logic [15:2] clr_v;

  pic_arb_if arb_bus ();

  pic_arbiter pic_arbiter_inst (
    .arb(arb_bus)
  );

  // arbiter requests: traps bypass every enable
  logic [15:0] req_v;
  assign req_v[0] = 1'b0;
  assign req_v[pic_pkg::IDX_TRAP] = software_trap | undefined_opcode_trap;
  assign req_v[pic_pkg::IDX_WDT:pic_pkg::IDX_ATRAP] = q_r.pending_latch[3:2];
  // one gate per maskable level
  for (genvar g = pic_pkg::IDX_MASK_LO; g <= 15; g++) begin : g_gate
    assign req_v[g] = q_r.pending_latch[g] & q_r.source_enable_flag[g] & q_r.master_enable_flag;
  end
  assign arb_bus.req = req_v;

  always_comb begin
    q_nxt = q_r;
    q_nxt.push = 1'b0;
    q_nxt.vvalid = 1'b0;
    q_nxt.rdata = 8'h00;
    set_v = '0;
    clr_v = '0;
    // source events
    set_v[pic_pkg::IDX_ATRAP] = address_trap_irq & ~trap_reset_select;
    set_v[pic_pkg::IDX_WDT] = watchdog_irq & ~wdt_reset_select;
    set_v[13:4] = maskable_irq;
    set_v[pic_pkg::IDX_SHARED15] = q_r.level15_source_select ? serial_transmit_irq
      : external_pin_four_irq;
    set_v[pic_pkg::IDX_SHARED16] = q_r.level16_source_select ? converter_done_irq
      : external_pin_five_irq;
    q_nxt.trap_rst = address_trap_irq & trap_reset_select;
    q_nxt.wdt_rst = watchdog_irq & wdt_reset_select;
    // register writes
    if (sfr_wr) begin
      case (sfr_addr)
        pic_pkg::ADDR_EN_LO: begin
          q_nxt.master_enable_flag = sfr_wdata[pic_pkg::IMF_BIT];
          q_nxt.source_enable_flag[7:4] = sfr_wdata[7:4];
        end
        pic_pkg::ADDR_EN_HI: begin
          q_nxt.source_enable_flag[15:8] = sfr_wdata;
        end
        pic_pkg::ADDR_IL_LO: begin
          clr_v[7:2] = ~sfr_wdata[7:2];
        end
        pic_pkg::ADDR_IL_HI: begin
          clr_v[15:8] = ~sfr_wdata;
        end
        pic_pkg::ADDR_SEL: begin
          q_nxt.level15_source_select = sfr_wdata[pic_pkg::SEL15_BIT];
          q_nxt.level16_source_select = sfr_wdata[pic_pkg::SEL16_BIT];
        end
        default: begin
        end
      endcase
    end
    // flag instructions
    if (enable_irq_op) begin
      q_nxt.master_enable_flag = 1'b1;
    end
    if (disable_irq_op) begin
      q_nxt.master_enable_flag = 1'b0;
    end
    if (maskable_return_op || nonmaskable_return_op) begin
      q_nxt.master_enable_flag = restored_imf;
    end
    // acceptance sequencer
    case (q_r.st)
      pic_pkg::PIC_IDLE: begin
        q_nxt.int_req = arb_bus.win_valid;
        if (instr_done && arb_bus.win_valid) begin
          q_nxt.win = arb_bus.win_idx;
          q_nxt.vector = arb_bus.win_vector;
          q_nxt.saved_imf = q_r.master_enable_flag;
          q_nxt.master_enable_flag = 1'b0;
          if (arb_bus.win_idx >= 4'(pic_pkg::IDX_ATRAP)) begin
            clr_v[arb_bus.win_idx] = 1'b1;
          end
          q_nxt.st = pic_pkg::PIC_ACCEPT;
          q_nxt.cnt = '0;
          q_nxt.busy = 1'b1;
          q_nxt.int_req = 1'b0;
        end
      end
      pic_pkg::PIC_ACCEPT: begin
        q_nxt.int_req = 1'b0;
        q_nxt.cnt = q_r.cnt + 1'b1;
        // pushes in machine cycles 2, 3 and 4
        for (int k = 1; k <= pic_pkg::STACK_PUSHES; k++) begin
          if (q_r.cnt == pic_pkg::CNT_W'(k * MACHINE_CLKS)) begin
            q_nxt.push = 1'b1;
            q_nxt.slot = 2'(k - 1);
          end
        end
        if (q_r.cnt == pic_pkg::CNT_W'(ACC_CLKS - 1)) begin
          q_nxt.st = pic_pkg::PIC_IDLE;
          q_nxt.busy = 1'b0;
          q_nxt.vvalid = 1'b1;
          q_nxt.cnt = '0;
        end
      end
      default: begin
        q_nxt.st = pic_pkg::PIC_IDLE;
        q_nxt.busy = 1'b0;
        q_nxt.cnt = '0;
      end
    endcase
    // new requests win over any clear in the same cycle
    q_nxt.pending_latch = (q_r.pending_latch & ~clr_v) | set_v;
    // register reads
    if (sfr_rd) begin
      case (sfr_addr)
        pic_pkg::ADDR_EN_LO: begin
          q_nxt.rdata = {q_r.source_enable_flag[7:4], 3'h0, q_r.master_enable_flag};
        end
        pic_pkg::ADDR_EN_HI: begin
          q_nxt.rdata = q_r.source_enable_flag[15:8];
        end
        pic_pkg::ADDR_IL_LO: begin
          q_nxt.rdata = {q_r.pending_latch[7:2], 2'h0};
        end
        pic_pkg::ADDR_IL_HI: begin
          q_nxt.rdata = q_r.pending_latch[15:8];
        end
        pic_pkg::ADDR_SEL: begin
          q_nxt.rdata = {6'h00, q_r.level15_source_select, q_r.level16_source_select};
        end
        default: begin
          q_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q_r.st <= pic_pkg::PIC_IDLE;
      q_r.cnt <= '0;
      q_r.master_enable_flag <= 1'b0;
      q_r.source_enable_flag <= 12'h000;
      q_r.pending_latch <= 14'h0000;
      q_r.level15_source_select <= pic_pkg::RST_SEL[pic_pkg::SEL15_BIT];
      q_r.level16_source_select <= pic_pkg::RST_SEL[pic_pkg::SEL16_BIT];
      q_r.win <= 4'h0;
      q_r.saved_imf <= 1'b0;
      q_r.int_req <= 1'b0;
      q_r.busy <= 1'b0;
      q_r.push <= 1'b0;
      q_r.slot <= pic_pkg::SLOT_STATUS;
      q_r.vvalid <= 1'b0;
      q_r.vector <= pic_pkg::VEC_RESET;
      q_r.rdata <= pic_pkg::RST_BYTE;
      q_r.trap_rst <= 1'b0;
      q_r.wdt_rst <= 1'b0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from the state register
  assign sfr_rdata = q_r.rdata;
  assign int_req = q_r.int_req;
  assign accept_busy = q_r.busy;
  assign stack_push = q_r.push;
  assign stack_slot = q_r.slot;
  assign stack_imf = q_r.saved_imf;
  assign vector_valid = q_r.vvalid;
  assign int_vector = q_r.vector;
  assign trap_reset_req = q_r.trap_rst;
  assign wdt_reset_req = q_r.wdt_rst;

endmodule
`default_nettype wire

//--- sim/pic_checker.sv
`default_nettype none
module pic_checker #(
  parameter int MACHINE_CLKS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // watched ports
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic address_trap_irq,
  input wire logic watchdog_irq,
  input wire logic trap_reset_select,
  input wire logic wdt_reset_select,
  input wire logic instr_done,
  input wire logic int_req,
  input wire logic accept_busy,
  input wire logic stack_push,
  input wire logic [1:0] stack_slot,
  input wire logic vector_valid,
  input wire logic [15:0] int_vector,
  input wire logic trap_reset_req,
  input wire logic wdt_reset_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] busy_cnt_r;
  // busy cycles of the running acceptance
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) busy_cnt_r <= 8'h00;
    else if (accept_busy) busy_cnt_r <= busy_cnt_r + 8'h01;
    else busy_cnt_r <= 8'h00;
  end
  vec_time_a: assert property (
    vector_valid |-> int'(busy_cnt_r) == 8 * MACHINE_CLKS) else $error("vector timing");
  push_time_a: assert property (
    stack_push |-> int'(busy_cnt_r) == MACHINE_CLKS * (int'(stack_slot) + 1) + 1) else $error("push timing");
  req_idle_a: assert property (
    int_req |-> !accept_busy) else $error("request while busy");
  take_start_a: assert property (
    $rose(accept_busy) |-> $past(instr_done) && !int_req) else $error("bad take");
  reset_vector_a: assert property (
    $rose(resetn) |-> int_vector == 16'hFFFE && !accept_busy) else $error("reset state");
  trap_reset_a: assert property (
    address_trap_irq |=> trap_reset_req == $past(trap_reset_select)) else $error("trap reset");
  wdt_reset_a: assert property (
    watchdog_irq |=> wdt_reset_req == $past(wdt_reset_select)) else $error("wdt reset");
  rdata_idle_a: assert property (
    !$past(sfr_rd) |-> sfr_rdata == 8'h00) else $error("read data idle");
  cover property (vector_valid);
  cover property (stack_push && stack_slot == 2'h2);
  cover property (trap_reset_req);
endmodule
bind pic_top pic_checker #(.MACHINE_CLKS(MACHINE_CLKS)) pic_checker_inst (.clk, .resetn, .sfr_rd, .sfr_rdata,
  .address_trap_irq, .watchdog_irq, .trap_reset_select, .wdt_reset_select, .instr_done, .int_req,
  .accept_busy, .stack_push, .stack_slot, .vector_valid, .int_vector, .trap_reset_req, .wdt_reset_req);
`default_nettype wire

//--- sim/pic_cpu_model.sv
`default_nettype none
module pic_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // controller side
  input wire logic int_req,
  input wire logic accept_busy,
  input wire logic [1:0] slow,
  output logic instr_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_r;
  // instruction boundary after slow extra cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      instr_done <= 1'b0;
      wait_r <= 2'h0;
    end else begin
      instr_done <= 1'b0;
      if (int_req && !accept_busy && !instr_done) begin
        if (wait_r == slow) begin
          instr_done <= 1'b1;
          wait_r <= 2'h0;
        end else wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/test_prioritized_interrupt_controller.sv
`default_nettype none
module test_prioritized_interrupt_controller;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, resetn, sfr_wr, sfr_rd, software_trap, undefined_opcode_trap, trap_reset_select;
  logic wdt_reset_select, restored_imf, instr_done, int_req, accept_busy, stack_push, stack_imf;
  logic vector_valid, address_trap_irq, watchdog_irq, external_pin_four_irq, serial_transmit_irq;
  logic external_pin_five_irq, converter_done_irq, enable_irq_op, disable_irq_op, maskable_return_op;
  logic trap_reset_req, wdt_reset_req, nonmaskable_return_op;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [13:4] mi;
  logic [9:0] ev;
  logic [1:0] stack_slot, slow;
  logic [15:0] int_vector;
  int bad_count, n_tests;
  assign {nonmaskable_return_op, maskable_return_op, disable_irq_op, enable_irq_op, converter_done_irq,
    external_pin_five_irq, serial_transmit_irq, external_pin_four_irq, watchdog_irq, address_trap_irq} = ev;
  `define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
  pic_top #(.MACHINE_CLKS(4)) pic_top_inst (.clk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .software_trap, .undefined_opcode_trap, .address_trap_irq, .watchdog_irq, .maskable_irq(mi),
    .external_pin_four_irq, .serial_transmit_irq, .external_pin_five_irq, .converter_done_irq,
    .trap_reset_select, .wdt_reset_select, .instr_done, .enable_irq_op, .disable_irq_op, .maskable_return_op,
    .nonmaskable_return_op, .restored_imf, .int_req, .accept_busy, .stack_push, .stack_slot, .stack_imf,
    .vector_valid, .int_vector, .trap_reset_req, .wdt_reset_req);
  pic_cpu_model pic_cpu_model_inst (.clk, .resetn, .int_req, .accept_busy, .slow, .instr_done);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    `CHK("sfr_rdata", e, sfr_rdata)
  endtask
  task automatic pulse(input logic [9:0] e, input logic [13:4] m);
    @(posedge clk);
    ev <= e;
    mi <= m;
    @(posedge clk);
    ev <= '0;
    mi <= '0;
    repeat (3) @(posedge clk);
  endtask
  task automatic acc(input logic [15:0] v);
    int i;
    int pushes = 0;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      #1;
      if (stack_push === 1'b1) begin
        `CHK("stack_slot", 2'(pushes), stack_slot)
        pushes++;
      end
      if (vector_valid === 1'b1) break;
    end
    if (i == 200) begin
      `CHK("vector_valid", 1'b1, vector_valid)
      give_verdict();
    end
    `CHK("push_count", pic_pkg::STACK_PUSHES, pushes)
    `CHK("int_vector", v, int_vector)
  endtask
  task automatic t_reset();
    for (int a = 8'h3A; a <= 8'h3E; a++) rd(8'(a), 8'h00);
    rd(8'h40, 8'h00);
    $display("done reset values");
  endtask
  task automatic t_latch();
    pulse(10'h014, 10'h002);
    rd(8'h3C, 8'h20);
    rd(8'h3D, 8'hC0);
    wr(8'h3C, 8'hFF);
    rd(8'h3C, 8'h20);
    wr(8'h3C, 8'hDF);
    wr(8'h3D, 8'h00);
    rd(8'h3C, 8'h00);
    rd(8'h3D, 8'h00);
    wr(8'h3E, 8'h03);
    pulse(10'h014, 10'h000);
    rd(8'h3D, 8'h00);
    pulse(10'h028, 10'h000);
    rd(8'h3D, 8'hC0);
    wr(8'h3D, 8'h00);
    $display("done latches");
  endtask
  task automatic t_mask();
    pulse(10'h040, 10'h000);
    rd(8'h3A, 8'h01);
    pulse(10'h080, 10'h000);
    wr(8'h3A, 8'h30);
    rd(8'h3A, 8'h30);
    pulse(10'h000, 10'h003);
    `CHK("int_req", 1'b0, int_req)
    pulse(10'h040, 10'h000);
    acc(16'hFFF6);
    `CHK("stack_imf", 1'b1, stack_imf)
    rd(8'h3A, 8'h30);
    rd(8'h3C, 8'h20);
    pulse(10'h100, 10'h000);
    acc(16'hFFF4);
    rd(8'h3C, 8'h00);
    $display("done masking");
  endtask
  task automatic t_nmi();
    @(posedge clk);
    trap_reset_select <= 1'b0;
    wdt_reset_select <= 1'b0;
    slow <= 2'h3;
    pulse(10'h003, 10'h000);
    acc(16'hFFFA);
    acc(16'hFFF8);
    @(posedge clk);
    trap_reset_select <= 1'b1;
    wdt_reset_select <= 1'b1;
    @(posedge clk);
    ev <= 10'h003;
    @(posedge clk);
    ev <= '0;
    #1;
    `CHK("trap_reset_req", 1'b1, trap_reset_req)
    `CHK("wdt_reset_req", 1'b1, wdt_reset_req)
    repeat (3) @(posedge clk);
    `CHK("int_req", 1'b0, int_req)
    for (int k = 1; k < 3; k++) begin
      @(posedge clk);
      {undefined_opcode_trap, software_trap} <= 2'(k);
      acc(16'hFFFC);
      @(posedge clk);
      {undefined_opcode_trap, software_trap} <= 2'h0;
    end
    repeat (40) @(posedge clk);
    pulse(10'h200, 10'h000);
    rd(8'h3A, 8'h31);
    $display("done traps");
  endtask
  initial begin
    {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, ev, mi} = '0;
    {software_trap, undefined_opcode_trap, slow} = '0;
    {trap_reset_select, wdt_reset_select, restored_imf} = 3'b111;
    bad_count = 0;
    n_tests = 0;
    resetn = 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_latch();
    t_mask();
    t_nmi();
    give_verdict();
  end
endmodule
`default_nettype wire
